//--- verilog/wdtc_pkg.sv
// Package of constants and types for the watchdog timer control block
package wdtc_pkg;

    // ************************************************************
    // Register byte addresses on the APB
    // ************************************************************
    localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS       = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK         = 8'h08;
    localparam logic [7:0] ADDR_COUNT            = 8'h0C;

    // ************************************************************
    // Field positions of watchdog_control
    // ************************************************************
    localparam int BIT_RESTART_COUNT      = 0;
    localparam int BIT_EXPIRY_RESET_EN    = 1;
    localparam int BIT_EXPIRY_RESET_FLAG  = 2;
    localparam int BIT_EXPIRY_IRQ_FLAG    = 3;
    localparam int BIT_PERIOD_SELECT_LOW  = 4;
    localparam int BIT_PERIOD_SELECT_HIGH = 5;
    localparam int BIT_EXPIRY_IRQ_EN      = 6;

    // ************************************************************
    // Field positions of the event status and mask registers
    // ************************************************************
    localparam int EVT_TIMEOUT     = 0;
    localparam int EVT_DELAY_START = 1;
    localparam int EVT_WDT_RESET   = 2;
    localparam int EVT_W           = 3;

    // ************************************************************
    // Widths, reset values and counts
    // ************************************************************
    localparam int          COUNT_W            = 27;
    localparam int          DELAY_W            = 10;
    localparam logic [9:0]  RESET_DELAY_CYCLES = 10'h200;
    localparam logic [1:0]  PERIOD_SEL_RESET   = 2'h0;
    localparam logic [2:0]  EVT_RESET          = 3'h0;

    // ************************************************************
    // Reset-delay sequencer states, one-hot
    // ************************************************************
    typedef enum logic [2:0] {
        WDTC_IDLE  = 3'b001,
        WDTC_DELAY = 3'b010,
        WDTC_FIRE  = 3'b100
    } wdtc_state_t;

endpackage : wdtc_pkg

//--- verilog/wdtc_counter.sv
// Free-running watchdog timeout counter with programmable limit
`timescale 1ns/1ps
module wdtc_counter (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          srst,
    // Control
    input  wire logic                          clear,
    input  wire logic                          enable,
    input  wire logic [wdtc_pkg::COUNT_W-1:0]  limit,
    // Result
    output logic                               expire,
    output logic      [wdtc_pkg::COUNT_W-1:0]  count
);

    logic [wdtc_pkg::COUNT_W-1:0] count_reg;
    logic [wdtc_pkg::COUNT_W-1:0] count_next;
    logic                         expire_reg;
    logic                         expire_next;
    wire  logic                   at_limit;

    // Terminal count; wraps so that each period gives one expiry
    assign at_limit    = (count_reg >= limit);
    assign expire_next = enable && !clear && at_limit;
    assign count_next  = (clear || at_limit) ? '0
                       : enable ? count_reg + 1'b1 : count_reg;

    // Count storage; holds still while the clock is gated off
    always_ff @(posedge clk) begin
        if (srst) begin
            count_reg  <= '0;
            expire_reg <= 1'b0;
        end else begin
            count_reg  <= count_next;
            expire_reg <= expire_next;
        end
    end

    assign expire = expire_reg;
    assign count  = count_reg;

endmodule : wdtc_counter

//--- verilog/wdtc_top.sv
// Watchdog timer control: APB register file, timeout, reset delay and flags
`timescale 1ns/1ps
module wdtc_top #(
    parameter logic [26:0] PERIOD_SEL0 = 27'h002_0000,
    parameter logic [26:0] PERIOD_SEL1 = 27'h010_0000,
    parameter logic [26:0] PERIOD_SEL2 = 27'h080_0000,
    parameter logic [26:0] PERIOD_SEL3 = 27'h400_0000
) (
    // Clock and power-on reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Other system resets (not power-on, not watchdog)
    input  wire logic        sys_reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Watchdog outputs
    output logic             expiry_irq,
    output logic             device_reset_req,
    // Event interrupt
    output logic             irq
);

    // ************************************************************
    // Declarations
    // ************************************************************
    // Control fields, next values and sequencer state
    logic                          restart_pulse_reg;
    logic                          restart_pulse_next;
    logic                          reset_en_reg;
    logic                          reset_en_next;
    logic                          reset_flag_reg;
    logic                          reset_flag_next;
    logic                          irq_flag_reg;
    logic                          irq_flag_next;
    logic                          irq_flag_d_reg;
    logic [1:0]                    period_sel_reg;
    logic [1:0]                    period_sel_next;
    logic                          irq_en_reg;
    logic                          irq_en_next;
    logic [wdtc_pkg::EVT_W-1:0]    evt_status_reg;
    logic [wdtc_pkg::EVT_W-1:0]    evt_status_next;
    logic [wdtc_pkg::EVT_W-1:0]    evt_mask_reg;
    logic [wdtc_pkg::EVT_W-1:0]    evt_mask_next;
    logic [wdtc_pkg::DELAY_W-1:0]  delay_cnt_reg;
    logic [wdtc_pkg::DELAY_W-1:0]  delay_cnt_next;
    wdtc_pkg::wdtc_state_t         state_reg;
    wdtc_pkg::wdtc_state_t         state_next;
    // Registered port drivers
    logic [31:0]                   prdata_reg;
    logic                          pready_reg;
    logic                          pslverr_reg;
    logic                          irq_reg;
    logic                          expiry_irq_reg;
    logic                          device_reset_reg;

    // Bus decode
    wire  logic                    setup_phase;
    wire  logic                    wr_en;
    wire  logic                    hit_ctrl;
    wire  logic                    hit_status;
    wire  logic                    hit_mask;
    wire  logic                    hit_count;
    wire  logic                    addr_ok;
    wire  logic                    wr_ctrl;
    wire  logic                    wr_status;
    wire  logic                    wr_mask;
    // Watchdog datapath
    wire  logic                    wdt_reset;
    wire  logic                    soft_reset;
    wire  logic                    wdt_enable;
    wire  logic                    timer_clear;
    wire  logic                    timeout;
    wire  logic                    irq_flag_rise;
    wire  logic                    delay_start;
    wire  logic                    delay_abort;
    wire  logic                    delay_done;
    wire  logic [26:0]             period_limit;
    wire  logic [wdtc_pkg::COUNT_W-1:0] timer_count;
    wire  logic [7:0]              ctrl_rd;
    wire  logic [31:0]             rd_mux;
    wire  logic [wdtc_pkg::EVT_W-1:0] evt_set;

    // ************************************************************
    // APB decode
    // ************************************************************
    // Zero-wait slave: ready is raised during the access phase from the setup phase
    // A write lands only at the access edge with ready high
    // Misaligned or unknown addresses are refused with an error
    assign setup_phase = psel && !penable;
    assign wr_en       = psel && penable && pwrite && pready_reg;
    assign hit_ctrl    = (paddr == wdtc_pkg::ADDR_WATCHDOG_CONTROL);
    assign hit_status  = (paddr == wdtc_pkg::ADDR_IRQ_STATUS);
    assign hit_mask    = (paddr == wdtc_pkg::ADDR_IRQ_MASK);
    assign hit_count   = (paddr == wdtc_pkg::ADDR_COUNT);
    assign addr_ok     = hit_ctrl || hit_status || hit_mask || hit_count;
    assign wr_ctrl     = wr_en && hit_ctrl;
    assign wr_status   = wr_en && hit_status;
    assign wr_mask     = wr_en && hit_mask;

    // ************************************************************
    // Reset sources
    // ************************************************************
    // A watchdog reset acts in the cycle the sequencer sits in its fire state
    // Other resets share this path; power-on reset stays separate
    // Keeping reset enable through it lets the watchdog fire again
    assign wdt_reset  = (state_reg == wdtc_pkg::WDTC_FIRE);
    assign soft_reset = sys_reset || wdt_reset;

    // ************************************************************
    // Timeout counter
    // ************************************************************
    // Both enables clear: counter frozen, acts as a gated clock
    // Restart acts one edge after the write, so counting starts from zero
    assign wdt_enable  = reset_en_reg || irq_en_reg;
    assign timer_clear = restart_pulse_reg || soft_reset;
    // Period chosen by the two-bit select field
    // The limit is one below the period because the count starts at zero
    assign period_limit = (period_sel_reg == 2'h0) ? PERIOD_SEL0 - 27'h1
                        : (period_sel_reg == 2'h1) ? PERIOD_SEL1 - 27'h1
                        : (period_sel_reg == 2'h2) ? PERIOD_SEL2 - 27'h1
                        : PERIOD_SEL3 - 27'h1;

    // A restart in the cycle of an expiry suppresses that expiry
    wdtc_counter u_counter (
        .clk    (clk),
        .srst   (srst),
        .clear  (timer_clear),
        .enable (wdt_enable),
        .limit  (period_limit),
        .expire (timeout),
        .count  (timer_count)
    );

    // ************************************************************
    // watchdog_control next values
    // ************************************************************
    // Restart is a one-cycle pulse, never stored for read-back
    assign restart_pulse_next = wr_ctrl && pwdata[wdtc_pkg::BIT_RESTART_COUNT] && !soft_reset;

    // Reset enable survives every reset except power-on
    assign reset_en_next = wr_ctrl ? pwdata[wdtc_pkg::BIT_EXPIRY_RESET_EN] : reset_en_reg;

    // Watchdog reset sets the flag; hardware set wins over a software clear
    assign reset_flag_next = wdt_reset ? 1'b1
                           : wr_ctrl ? pwdata[wdtc_pkg::BIT_EXPIRY_RESET_FLAG]
                           : reset_flag_reg;

    // Timeout sets the interrupt flag; software may set or clear it, set wins
    // Limitation: a software set also arms the reset delay
    assign irq_flag_next = soft_reset ? 1'b0
                         : timeout ? 1'b1
                         : wr_ctrl ? pwdata[wdtc_pkg::BIT_EXPIRY_IRQ_FLAG]
                         : irq_flag_reg;

    // Period select clears on every reset
    assign period_sel_next = soft_reset ? wdtc_pkg::PERIOD_SEL_RESET
                           : wr_ctrl ? pwdata[wdtc_pkg::BIT_PERIOD_SELECT_HIGH:wdtc_pkg::BIT_PERIOD_SELECT_LOW]
                           : period_sel_reg;

    // Interrupt enable clears on every reset as well
    assign irq_en_next = soft_reset ? 1'b0
                       : wr_ctrl ? pwdata[wdtc_pkg::BIT_EXPIRY_IRQ_EN]
                       : irq_en_reg;

    // Control register storage; power-on reset clears everything
    always_ff @(posedge clk) begin
        if (srst) begin
            restart_pulse_reg <= 1'b0;
            reset_en_reg      <= 1'b0;
            reset_flag_reg    <= 1'b0;
            irq_flag_reg      <= 1'b0;
            irq_flag_d_reg    <= 1'b0;
            period_sel_reg    <= wdtc_pkg::PERIOD_SEL_RESET;
            irq_en_reg        <= 1'b0;
        end else begin
            restart_pulse_reg <= restart_pulse_next;
            reset_en_reg      <= reset_en_next;
            reset_flag_reg    <= reset_flag_next;
            irq_flag_reg      <= irq_flag_next;
            irq_flag_d_reg    <= irq_flag_reg;
            period_sel_reg    <= period_sel_next;
            irq_en_reg        <= irq_en_next;
        end
    end

    // ************************************************************
    // Reset-delay sequencer
    // ************************************************************
    // Only a rising flag starts the delay, so an abort by restart does not re-arm at once
    // Rest waits for a rising flag, delay counts 512 cycles, fire lasts one
    // Trade-off: an abort returns to rest rather than pausing the count
    assign irq_flag_rise = irq_flag_reg && !irq_flag_d_reg;
    assign delay_start   = irq_flag_rise && reset_en_reg;
    assign delay_abort   = restart_pulse_reg || !irq_flag_reg || soft_reset;
    assign delay_done    = (delay_cnt_reg == wdtc_pkg::RESET_DELAY_CYCLES - 10'h1);

    // Next state; dropping reset enable mid-delay also suppresses the reset
    always_comb begin
        state_next     = state_reg;
        delay_cnt_next = delay_cnt_reg;
        unique case (state_reg)
            wdtc_pkg::WDTC_IDLE: begin
                // Delay count stays at zero until a delay starts
                delay_cnt_next = '0;
                if (delay_start) begin
                    state_next = wdtc_pkg::WDTC_DELAY;
                end
            end
            wdtc_pkg::WDTC_DELAY: begin
                // An abort wins over completion in the same cycle
                if (delay_abort || !reset_en_reg) begin
                    state_next     = wdtc_pkg::WDTC_IDLE;
                    delay_cnt_next = '0;
                end else if (delay_done) begin
                    state_next = wdtc_pkg::WDTC_FIRE;
                end else begin
                    delay_cnt_next = delay_cnt_reg + 10'h1;
                end
            end
            wdtc_pkg::WDTC_FIRE: begin
                // One cycle of fire, then back to rest
                state_next     = wdtc_pkg::WDTC_IDLE;
                delay_cnt_next = '0;
            end
            default: begin
                // Illegal code: recover to rest
                state_next     = wdtc_pkg::WDTC_IDLE;
                delay_cnt_next = '0;
            end
        endcase
    end

    // Sequencer storage
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg     <= wdtc_pkg::WDTC_IDLE;
            delay_cnt_reg <= '0;
        end else begin
            state_reg     <= state_next;
            delay_cnt_reg <= delay_cnt_next;
        end
    end

    // ************************************************************
    // Event status and mask
    // ************************************************************
    // Event sources: reset issued, delay started, timeout
    // Reset issued mirrors the move into the fire state
    assign evt_set = {delay_done && (state_reg == wdtc_pkg::WDTC_DELAY)
                          && !delay_abort && reset_en_reg,
                      delay_start && (state_reg == wdtc_pkg::WDTC_IDLE),
                      timeout};

    // Sticky bits, write one to clear; a new event in the same cycle wins
    assign evt_status_next = (evt_status_reg & ~(wr_status ? pwdata[wdtc_pkg::EVT_W-1:0]
                                                           : wdtc_pkg::EVT_RESET)) | evt_set;
    assign evt_mask_next   = wr_mask ? pwdata[wdtc_pkg::EVT_W-1:0] : evt_mask_reg;

    // Status and mask keep their values through all but power-on reset
    always_ff @(posedge clk) begin
        if (srst) begin
            evt_status_reg <= wdtc_pkg::EVT_RESET;
            evt_mask_reg   <= wdtc_pkg::EVT_RESET;
        end else begin
            evt_status_reg <= evt_status_next;
            evt_mask_reg   <= evt_mask_next;
        end
    end

    // ************************************************************
    // Read mux
    // ************************************************************
    // Restart and the spare top bit always read as zero
    assign ctrl_rd = {1'b0,
                      irq_en_reg,
                      period_sel_reg,
                      irq_flag_reg,
                      reset_flag_reg,
                      reset_en_reg,
                      1'b0};

    // Unmapped addresses read zero; the error flag is raised separately
    // The count is captured at setup, so it reads one cycle old
    assign rd_mux = hit_ctrl   ? {24'h00_0000, ctrl_rd}
                  : hit_status ? {29'h0000_0000, evt_status_reg}
                  : hit_mask   ? {29'h0000_0000, evt_mask_reg}
                  : hit_count  ? {5'h00, timer_count}
                  : 32'h0000_0000;

    // ************************************************************
    // Registered outputs
    // ************************************************************
    // Read data is sampled in setup so it stands steady through the access phase
    // Interrupt and reset outputs use next values to line up with the flags
    // The reset request is one cycle long; system reset logic must stretch it
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata_reg       <= 32'h0000_0000;
            pready_reg       <= 1'b0;
            pslverr_reg      <= 1'b0;
            irq_reg          <= 1'b0;
            expiry_irq_reg   <= 1'b0;
            device_reset_reg <= 1'b0;
        end else begin
            prdata_reg       <= (setup_phase && !pwrite) ? rd_mux : 32'h0000_0000;
            pready_reg       <= setup_phase;
            pslverr_reg      <= setup_phase && !addr_ok;
            irq_reg          <= |(evt_status_next & evt_mask_next);
            expiry_irq_reg   <= irq_flag_next && irq_en_next;
            device_reset_reg <= (state_next == wdtc_pkg::WDTC_FIRE);
        end
    end

    // Ports come straight from their flip-flops
    assign prdata           = prdata_reg;
    assign pready           = pready_reg;
    assign pslverr          = pslverr_reg;
    assign irq              = irq_reg;
    assign expiry_irq       = expiry_irq_reg;
    assign device_reset_req = device_reset_reg;

endmodule : wdtc_top

//--- testbench/wdtc_checker.sv
// Port-level checker for the watchdog timer control block
`timescale 1ns/1ps
module wdtc_checker (
    // Clock and resets
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        sys_reset,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Watchdog and event outputs
    input wire logic        expiry_irq,
    input wire logic        device_reset_req,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // ********************************************************
    // Helper logic
    // ********************************************************
    // Decode of the register map and of a completed control write
    wire mapped  = (paddr <= wdtc_pkg::ADDR_COUNT) && (paddr[1:0] == 2'h0);
    wire wr_ctrl = psel && penable && pready && pwrite && (paddr == wdtc_pkg::ADDR_WATCHDOG_CONTROL);
    logic        ewt_sh;
    logic [11:0] since_irq;

    // Shadow of reset enable; only power-on reset clears it
    always_ff @(posedge clk) begin
        if (srst)
            ewt_sh <= 1'b0;
        else if (wr_ctrl)
            ewt_sh <= pwdata[wdtc_pkg::BIT_EXPIRY_RESET_EN];
    end

    // Cycles since the interrupt rose, saturating so stale episodes stay harmless
    always_ff @(posedge clk) begin
        if (srst || $rose(expiry_irq))
            since_irq <= 12'h000;
        else if (since_irq != 12'hFFF)
            since_irq <= since_irq + 12'h001;
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
    a_restart_zero: assert property (pready && !pwrite && paddr == wdtc_pkg::ADDR_WATCHDOG_CONTROL
        |-> prdata[0] == 1'b0 && prdata[7] == 1'b0) else $error("restart bit read as one");
    a_unmapped_error: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pslverr |-> pready && !mapped) else $error("error on mapped access");
    a_write_data_zero: assert property (pready && pwrite |-> prdata == 32'h0) else $error("read data on write");
    a_reset_needs_enable: assert property (device_reset_req |-> ewt_sh || $past(ewt_sh))
        else $error("device reset without reset enable");
    a_reset_pulse_single: assert property (device_reset_req |=> !device_reset_req)
        else $error("device reset longer than one cycle");
    a_delay_length: assert property (device_reset_req |-> since_irq >= 12'd510)
        else $error("device reset too soon after timeout");
    a_reset_quiet: assert property ($fell(srst) |-> !pready && !device_reset_req && !expiry_irq && !irq)
        else $error("outputs active after power-on reset");
    a_sysreset_irq: assert property (sys_reset |-> ##3 !expiry_irq)
        else $error("interrupt flag survived system reset");

    // Main scenarios reached
    cover property (device_reset_req);
    cover property (pslverr);
    cover property ($rose(expiry_irq));
endmodule : wdtc_checker

bind wdtc_top wdtc_checker u_chk (.clk(clk), .srst(srst), .sys_reset(sys_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .expiry_irq(expiry_irq), .device_reset_req(device_reset_req), .irq(irq));

//--- testbench/tb_wdtc_top.sv
// Self-checking testbench of the watchdog timer control block
`timescale 1ns/1ps
module tb_wdtc_top;
    // ********************************************************
    // Signals and bookkeeping
    // ********************************************************
    logic        clk, srst, sys_reset, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, expiry_irq, device_reset_req, irq;
    logic [32:0] q[$];
    logic [32:0] m;
    int          fails, checks, pulses, n;
    localparam logic [7:0] CTL = wdtc_pkg::ADDR_WATCHDOG_CONTROL;
    localparam logic [7:0] STS = wdtc_pkg::ADDR_IRQ_STATUS;
    localparam logic [7:0] MSK = wdtc_pkg::ADDR_IRQ_MASK;
    localparam logic [7:0] CNT = wdtc_pkg::ADDR_COUNT;
    localparam int         P[4] = '{16, 32, 64, 128};

    // Short periods keep the run brief
    wdtc_top #(.PERIOD_SEL0(27'h10), .PERIOD_SEL1(27'h20), .PERIOD_SEL2(27'h40), .PERIOD_SEL3(27'h80)) dut (
        .clk(clk), .srst(srst), .sys_reset(sys_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .expiry_irq(expiry_irq), .device_reset_req(device_reset_req), .irq(irq));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ********************************************************
    // Tasks
    // ********************************************************
    task automatic end_of_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // One APB transfer; the expected answer is queued for the monitor
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        logic bad;
        bad = (a > CNT) || (a[1:0] != 2'h0);
        q.push_back({bad, (wr || bad) ? 32'h0 : e});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer

    // Bounded wait for the watchdog interrupt
    task automatic wait_x(output int c);
        c = 0;
        while (expiry_irq !== 1'b1 && c < 2000) begin
            @(posedge clk);
            c++;
        end
    endtask : wait_x

    // Monitor: compares each APB answer with the oldest note, counts reset pulses
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && q.size() > 0) begin
            m = q.pop_front();
            cmp("prdata", m[31:0], prdata);
            cmp("pslverr", {31'h0, m[32]}, {31'h0, pslverr});
        end
        if (device_reset_req === 1'b1)
            pulses++;
    end

    // Watchdog against a hung run, far beyond the roughly 1500 cycles needed
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_of_test();
    end

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        {srst, sys_reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 44'h0};
        fails = 0;
        checks = 0;
        pulses = 0;
        void'($urandom(71));
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 4; i++) xfer(1'b0, 8'(4 * i), 32'h0, 32'h0);
        xfer(1'b1, CTL, 32'h31, 32'h0);
        xfer(1'b0, CTL, 32'h0, 32'h30);
        xfer(1'b1, CNT, $urandom, 32'h0);
        xfer(1'b0, CNT, 32'h0, 32'h0);
        xfer(1'b1, {2'h1, 6'($urandom)}, $urandom, 32'h0);
        xfer(1'b0, {2'h3, 6'($urandom)}, 32'h0, 32'h0);
        // Each period select in turn, interrupt only
        xfer(1'b1, MSK, 32'h1, 32'h0);
        for (int s = 0; s < 4; s++) begin
            xfer(1'b1, CTL, 32'h41 | (32'(s) << 4), 32'h0);
            wait_x(n);
            cmp("period", 32'h1, 32'(n + 4 >= P[s] && n <= P[s] + 4));
            xfer(1'b1, CTL, 32'h0, 32'h0);
        end
        cmp("irq", 32'h1, {31'h0, irq});
        xfer(1'b0, STS, 32'h0, 32'h1);
        xfer(1'b1, MSK, 32'h0, 32'h0);
        cmp("irq masked", 32'h0, {31'h0, irq});
        xfer(1'b1, STS, 32'h7, 32'h0);
        xfer(1'b1, MSK, 32'h7, 32'h0);
        xfer(1'b0, STS, 32'h0, 32'h0);
        // Expiry with reset and interrupt enabled, then the delayed reset
        xfer(1'b1, CTL, 32'h42, 32'h0);
        wait_x(n);
        cmp("irq with reset", 32'h1, {31'h0, expiry_irq});
        n = 0;
        while (pulses == 0 && n < 600) begin
            @(posedge clk);
            n++;
        end
        cmp("delay", 32'h1, 32'(n >= 505 && n <= 520));
        xfer(1'b0, CTL, 32'h0, 32'h06);
        xfer(1'b0, STS, 32'h0, 32'h7);
        // Restarts while the delay runs hold the reset off
        xfer(1'b1, CTL, 32'h43, 32'h0);
        wait_x(n);
        repeat (180) xfer(1'b1, CTL, 32'h4B, 32'h0);
        xfer(1'b1, CTL, 32'h0, 32'h0);
        cmp("pulses", 32'h1, 32'(pulses));
        // Other resets keep reset enable and flag; power-on clears them
        xfer(1'b1, CTL, 32'h76, 32'h0);
        sys_reset <= 1'b1;
        @(posedge clk);
        sys_reset <= 1'b0;
        @(posedge clk);
        xfer(1'b0, CTL, 32'h0, 32'h06);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        xfer(1'b0, CTL, 32'h0, 32'h0);
        xfer(1'b0, MSK, 32'h0, 32'h0);
        end_of_test();
    end
endmodule : tb_wdtc_top
